//--- rtl/sbsr_pkg.sv
// Purpose: constants for the split bus status register
// Assumes: 32-bit register at configuration offset 0x44
// Notes:   field positions, fixed values and reset values
package sbsr_pkg;
  localparam logic [7:0]  SBSR_OFFSET          = 8'h44;
  localparam int          SBSR_RX_ERR_BIT      = 29;
  localparam int          SBSR_CUM_LO          = 26;
  localparam int          SBSR_OST_LO          = 23;
  localparam int          SBSR_MRC_LO          = 21;
  localparam int          SBSR_CPLX_BIT        = 20;
  localparam int          SBSR_UNEXP_BIT       = 19;
  localparam int          SBSR_DISC_BIT        = 18;
  localparam int          SBSR_FAST_BIT        = 17;
  localparam int          SBSR_WIDE_BIT        = 16;
  localparam int          SBSR_BUS_LO          = 8;
  localparam int          SBSR_DEV_LO          = 3;
  localparam logic [2:0]  SBSR_OUTSTANDING_VAL = 3'h2;
  localparam logic [1:0]  SBSR_READ_COUNT_VAL  = 2'h3;
  localparam logic [7:0]  SBSR_BUS_RESET       = 8'hFF;
  localparam logic [4:0]  SBSR_DEV_RESET       = 5'h1F;
  localparam logic [2:0]  SBSR_FUNC_VAL        = 3'h0;
endpackage

//--- rtl/sbsr_status_reg.sv
// Purpose: split bus status register with capture of bus and device numbers
// Assumes: config decode done upstream; AD inputs already synchronous to core_clk
// Notes:   read data registered one cycle after cfgRdEn
`timescale 1ns/1ps
module sbsr_status_reg
  import sbsr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clkEn,
  input  wire logic        cfgRdEn,
  input  wire logic        cfgWrEn,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [31:0] cfgWrData,
  input  wire logic        addrPhaseCfgWr,
  input  wire logic        attrPhaseCfgWr,
  input  wire logic [31:0] adBus,
  input  wire logic [1:0]  read_byte_count_setting,
  input  wire logic        rxSplitErrMsg,
  input  wire logic        unexpectedCompletion,
  input  wire logic        completionDiscarded,
  output logic      [31:0] cfgRdData,
  output logic      [15:0] requesterId
);
  import sbsr_pkg::*;

  // flag order: [2] rx error msg, [1] unexpected, [0] discarded
  logic [2:0]  flags_r;
  logic [2:0]  flags_nxt;
  logic [2:0]  events;
  logic [2:0]  clearMask;

  logic [7:0]  bus_segment_number_r;
  logic [7:0]  bus_segment_number_nxt;
  logic [4:0]  device_slot_number_r;
  logic [4:0]  device_slot_number_nxt;

  logic [31:0] cfgRdData_nxt;
  logic [15:0] requesterId_nxt;
  logic        wrHit;
  logic        rdHit;
  logic [2:0]  cumSize;
  logic [31:0] statusWord;

  // strobe qualified by the register offset
  function automatic logic hitsStatus(
    input logic       strobe,
    input logic [7:0] addr
  );
    hitsStatus = strobe && (addr == SBSR_OFFSET);
  endfunction

  // cumulative read size code for each read byte count setting
  function automatic logic [2:0] cumReadSize(
    input logic [1:0] setting
  );
    logic [2:0] size;
    size = 3'h1;
    unique case (setting)
      2'h0: begin
        size = 3'h1;
      end
      2'h1: begin
        size = 3'h2;
      end
      2'h2: begin
        size = 3'h3;
      end
      2'h3: begin
        size = 3'h4;
      end
    endcase
    cumReadSize = size;
  endfunction

  // ------------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------------
  always_comb begin
    wrHit  = hitsStatus(cfgWrEn, cfgAddr);
    rdHit  = hitsStatus(cfgRdEn, cfgAddr);
    events = {rxSplitErrMsg, unexpectedCompletion, completionDiscarded};
    clearMask = 3'h0;
    // off-address writes and writes of zero leave the flags alone
    if (wrHit) begin
      clearMask[2] = cfgWrData[SBSR_RX_ERR_BIT];
      clearMask[1] = cfgWrData[SBSR_UNEXP_BIT];
      clearMask[0] = cfgWrData[SBSR_DISC_BIT];
    end
  end

  // ------------------------------------------------------------------
  // clearable error flags, one slice per flag
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_flag
      // set is applied after clear so a coinciding event is not lost while clkEn is high
      always_comb begin
        flags_nxt[gi] = flags_r[gi];
        if (clearMask[gi]) begin
          flags_nxt[gi] = 1'b0;
        end
        if (events[gi]) begin
          flags_nxt[gi] = 1'b1;
        end
      end

      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          flags_r[gi] <= 1'b0;
        end else if (clkEn) begin
          flags_r[gi] <= flags_nxt[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // bus segment number, latched in the attribute phase
  // ------------------------------------------------------------------
  always_comb begin
    bus_segment_number_nxt = bus_segment_number_r;
    if (attrPhaseCfgWr) begin
      bus_segment_number_nxt = adBus[7:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bus_segment_number_r <= SBSR_BUS_RESET;
    end else if (clkEn) begin
      bus_segment_number_r <= bus_segment_number_nxt;
    end
  end

  // ------------------------------------------------------------------
  // device number, latched in the address phase
  // ------------------------------------------------------------------
  always_comb begin
    device_slot_number_nxt = device_slot_number_r;
    if (addrPhaseCfgWr) begin
      device_slot_number_nxt = adBus[15:11];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      device_slot_number_r <= SBSR_DEV_RESET;
    end else if (clkEn) begin
      device_slot_number_r <= device_slot_number_nxt;
    end
  end

  // ------------------------------------------------------------------
  // status word assembly
  // ------------------------------------------------------------------
  always_comb begin
    // setting comes from software in the capability register
    cumSize    = cumReadSize(read_byte_count_setting);
    statusWord = 32'h0000_0000;
    statusWord[SBSR_RX_ERR_BIT]  = flags_r[2];
    statusWord[SBSR_CUM_LO +: 3] = cumSize;
    statusWord[SBSR_OST_LO +: 3] = SBSR_OUTSTANDING_VAL;
    statusWord[SBSR_MRC_LO +: 2] = SBSR_READ_COUNT_VAL;
    statusWord[SBSR_CPLX_BIT]    = 1'b1;
    statusWord[SBSR_UNEXP_BIT]   = flags_r[1];
    statusWord[SBSR_DISC_BIT]    = flags_r[0];
    statusWord[SBSR_FAST_BIT]    = 1'b1;
    statusWord[SBSR_WIDE_BIT]    = 1'b1;
    statusWord[SBSR_BUS_LO +: 8] = bus_segment_number_r;
    statusWord[SBSR_DEV_LO +: 5] = device_slot_number_r;
    statusWord[2:0]              = SBSR_FUNC_VAL;
  end

  // ------------------------------------------------------------------
  // registered read data
  // ------------------------------------------------------------------
  always_comb begin
    // zero outside a hit read keeps a shared read mux a plain OR
    cfgRdData_nxt = 32'h0000_0000;
    if (rdHit) begin
      cfgRdData_nxt = statusWord;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfgRdData <= 32'h0000_0000;
    end else if (clkEn) begin
      cfgRdData <= cfgRdData_nxt;
    end
  end

  // ------------------------------------------------------------------
  // requester and completer identifier
  // ------------------------------------------------------------------
  always_comb begin
    // built from next values so the id follows a capture at once
    requesterId_nxt = {bus_segment_number_nxt, device_slot_number_nxt,
                       SBSR_FUNC_VAL};
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      requesterId <= {SBSR_BUS_RESET, SBSR_DEV_RESET, SBSR_FUNC_VAL};
    end else if (clkEn) begin
      requesterId <= requesterId_nxt;
    end
  end
endmodule

//--- verif/sbsr_checker.sv
// Purpose: port checks; Assumes: one clock; Notes: hit is a read of 0x44
`timescale 1ns/1ps
module sbsr_checker import sbsr_pkg::*; (input wire logic core_clk, reset, clkEn, cfgRdEn,
  attrPhaseCfgWr, rxSplitErrMsg, addrPhaseCfgWr, unexpectedCompletion, completionDiscarded,
  input wire logic [1:0] read_byte_count_setting,
  input wire logic [7:0] cfgAddr, input wire logic [15:0] requesterId,
  input wire logic [31:0] adBus, cfgRdData);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire hit = clkEn && cfgRdEn && cfgAddr == SBSR_OFFSET;
  AST_CUM: assert property (hit |=> cfgRdData[28:26] == $past(read_byte_count_setting) + 1)
    else $error("cum");
  AST_OST: assert property (hit |=> cfgRdData[25:23] == 2) else $error("ost");
  AST_MRC: assert property (hit |=> cfgRdData[22:21] == 3) else $error("mrc");
  AST_CAP: assert property (hit |=> {cfgRdData[20], cfgRdData[17:16]} == 7) else $error("cap");
  AST_RSV: assert property (hit |=> cfgRdData[31:30] == 0 && cfgRdData[2:0] == 0)
    else $error("rsv");
  AST_ID: assert property (hit |=> cfgRdData[15:0] == $past(requesterId)) else $error("id");
  AST_BUS: assert property (clkEn && attrPhaseCfgWr |=> requesterId[15:8] == $past(adBus[7:0]))
    else $error("bus");
  AST_RX: assert property (clkEn && rxSplitErrMsg ##1 hit |=> cfgRdData[29]) else $error("rx");
  AST_UNX: assert property (clkEn && unexpectedCompletion ##1 hit |=> cfgRdData[19])
    else $error("unexpected");
  AST_DSC: assert property (clkEn && completionDiscarded ##1 hit |=> cfgRdData[18])
    else $error("discarded");
  AST_DEV: assert property (clkEn && addrPhaseCfgWr |=> requesterId[7:3] == $past(adBus[15:11]))
    else $error("dev");
  AST_FRZ: assert property (!clkEn |=> $stable(requesterId) && $stable(cfgRdData))
    else $error("freeze");
endmodule
bind sbsr_status_reg sbsr_checker u_chk (.*);

//--- verif/sbsr_host_model.sv
// Purpose: host issuing config writes; Assumes: go lasts one cycle; Notes: idle AD toggles
`timescale 1ns/1ps
module sbsr_host_model (input wire logic core_clk, go, input wire logic [7:0] bus,
  input wire logic [4:0] dev, output logic addrPhaseCfgWr = 1'b0, attrPhaseCfgWr = 1'b0,
  output logic [31:0] adBus = 32'hA5A50F0F);
  always @(posedge core_clk) begin
    addrPhaseCfgWr <= go;
    attrPhaseCfgWr <= addrPhaseCfgWr;
    adBus <= go ? {16'h0, dev, 11'h7FF} : addrPhaseCfgWr ? {~adBus[31:8], bus} : ~adBus;
  end
endmodule

//--- verif/tb_top.sv
// Purpose: bench; Assumes: clkEn high except for one gated write; Notes: inputs move 1 ns after the edge
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 0, reset = 1, clkEn = 1, cfgRdEn = 0, cfgWrEn = 0, go = 0;
  logic rxSplitErrMsg = 0, unexpectedCompletion = 0, completionDiscarded = 0;
  logic addrPhaseCfgWr, attrPhaseCfgWr;
  logic [1:0] read_byte_count_setting = 2'h0;
  logic [4:0] dev = 5'h1F;
  logic [7:0] cfgAddr = 8'h0, bus = 8'hFF;
  logic [15:0] requesterId;
  logic [31:0] cfgWrData = 32'h0, adBus, cfgRdData;
  int failures = 0, n_tests = 0;
  sbsr_host_model u_sbsr_host_model (.*);
  sbsr_status_reg u_sbsr_status_reg (.*);
  initial forever #2.5 core_clk = ~core_clk;
  task chk(string n, logic [31:0] e, v);
    n_tests++;
    if (v !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, v);
    end
  endtask
  // strobes are never dropped here, so no signal moves twice in one step
  task acc(logic w, logic [7:0] a, logic [31:0] d, logic [2:0] e = 3'h0);
    {cfgWrEn, cfgRdEn, cfgAddr, cfgWrData} = {w, !w, a, d};
    {rxSplitErrMsg, unexpectedCompletion, completionDiscarded} = e;
    @(posedge core_clk) #1;
  endtask
  task rd(logic [2:0] f);
    acc(1'b0, 8'h44, 32'h0);
    chk("status", {2'h0, f[2], read_byte_count_setting + 3'h1, 6'h17, f[1:0], 2'h3, bus, dev,
      3'h0}, cfgRdData);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    #1 reset = 0;
    for (int s = 0; s < 4; s++) begin
      read_byte_count_setting = 2'(s);
      rd(3'h0);
    end
    $display("constants done");
    acc(1'b1, 8'h40, 32'hFFFFFFFF, 3'h7);
    rd(3'h7);
    acc(1'b0, 8'h40, 32'h0);
    chk("miss", 32'h0, cfgRdData);
    acc(1'b1, 8'h44, 32'hDFF3FFFF);
    rd(3'h7);
    acc(1'b1, 8'h44, 32'h200C0000, 3'h4);
    rd(3'h4);
    acc(1'b1, 8'h44, 32'h20000000);
    rd(3'h0);
    acc(1'b0, 8'h40, 32'h0, 3'h2);
    rd(3'h2);
    acc(1'b1, 8'h44, 32'h00080000, 3'h1);
    rd(3'h1);
    acc(1'b1, 8'h44, 32'h00040000);
    rd(3'h0);
    clkEn = 0;
    acc(1'b1, 8'h44, 32'h0, 3'h7);
    clkEn = 1;
    rd(3'h0);
    $display("flags done");
    {bus, dev, go} = {8'h5A, 5'h0B, 1'b1};
    @(posedge core_clk) #1 go = 0;
    repeat (2) @(posedge core_clk) #1;
    rd(3'h0);
    chk("id", {bus, dev, 3'h0}, requesterId);
    $display("capture done");
    acc(1'b0, 8'h40, 32'h0, 3'h7);
    reset = 1;
    repeat (2) @(posedge core_clk) #1;
    reset = 0;
    {bus, dev} = {8'hFF, 5'h1F};
    rd(3'h0);
    chk("id", {bus, dev, 3'h0}, requesterId);
    $display("reset done");
    end_sim;
  end
endmodule
